// ==== fp_bit_ops_regs.svh ====
`ifndef FP_BIT_OPS_REGS_SVH
`define FP_BIT_OPS_REGS_SVH

// ----------------------------------------------------------------
// Field layout of a floating-point register
// ----------------------------------------------------------------
`define FPB_SIG_W        64
`define FPB_EXP_W        17
`define FPB_INT_EXP      17'h1_003E
`define FPB_SIGN_POS     1'b0
`define FPB_NATVAL_SIG   64'h0000_0000_0000_0000
`define FPB_NATVAL_EXP   17'h1_FFFE
`define FPB_NATVAL_SIGN  1'b0

// ----------------------------------------------------------------
// Memory format constants
// ----------------------------------------------------------------
`define FPB_SGL_BIAS     8'h7F
`define FPB_DBL_BIAS     11'h3FF
`define FPB_REG_BIAS     17'h0_FFFF
`define FPB_EXP_MAX      17'h1_FFFF

`endif

// ==== fp_bit_ops_pkg.sv ====
package fp_bit_ops_pkg;

    // Operation selector
    typedef enum logic [3:0] {
        OP_HALF_SWAP          = 4'h0,
        OP_HALF_SWAP_NEG_LEFT = 4'h1,
        OP_HALF_SWAP_NEG_RIGHT= 4'h2,
        OP_SXT_LEFT           = 4'h3,
        OP_SXT_RIGHT          = 4'h4,
        OP_XOR                = 4'h5,
        OP_GET_SINGLE         = 4'h6,
        OP_GET_DOUBLE         = 4'h7,
        OP_GET_EXP            = 4'h8,
        OP_GET_SIG            = 4'h9
    } fp_op_e;

    // Floating-point register value
    typedef struct packed {
        logic        sign;
        logic [16:0] exponent;
        logic [63:0] significand;
    } float_reg_s;

endpackage

// ==== fp_mem_if.sv ====
`timescale 1ns/1ps
// Carries a register value to the memory-format converter and back
interface fp_mem_if;
    import fp_bit_ops_pkg::*;
    float_reg_s  src;
    logic [31:0] single_val;
    logic [63:0] double_val;
    modport user (output src, input single_val, input double_val);
    modport conv (input src, output single_val, output double_val);
endinterface

// ==== fp_mem_format.sv ====
`timescale 1ns/1ps
`include "fp_bit_ops_regs.svh"

// Converts register format to single and double memory format
module fp_mem_format
    import fp_bit_ops_pkg::*;
(
    fp_mem_if.conv m
);

    logic [16:0] unb;
    logic        is_zero_exp;
    logic        is_max_exp;
    logic [7:0]  s_exp;
    logic [10:0] d_exp;

    // ----------------------------------------------------------------
    // Exponent rebias, truncating significand
    // ----------------------------------------------------------------
    always_comb
    begin
        is_zero_exp = (m.src.exponent == 17'h0_0000) || !m.src.significand[63];
        is_max_exp  = (m.src.exponent == `FPB_EXP_MAX);
        unb         = m.src.exponent - `FPB_REG_BIAS;
        s_exp       = is_zero_exp ? 8'h00 : (is_max_exp ? 8'hFF : 8'(unb + 17'(`FPB_SGL_BIAS)));
        d_exp       = is_zero_exp ? 11'h000 : (is_max_exp ? 11'h7FF : 11'(unb + 17'(`FPB_DBL_BIAS)));
        m.single_val = {m.src.sign, s_exp, m.src.significand[62:40]};
        m.double_val = {m.src.sign, d_exp, m.src.significand[62:11]};
    end

endmodule

// ==== fp_register_bit_ops.sv ====
`timescale 1ns/1ps
`include "fp_bit_ops_regs.svh"

// How it works
// - Half-swap, sign-extend and XOR give not-a-thing when either source is one.
// - Their other results get exponent 0x1003E and positive sign.
// - Plain swap: upper half from third source low, lower from second high.
// - Negate-right swap inverts second source bit 63 into result bit 31.
// - Negate-left swap inverts sign of the upper result half.
// - Sign-extend replicates second source half sign, joins third source half.
// - XOR stores bitwise XOR of both source significands.
// - Single and double moves write the memory representation to the int reg.
// - Single move clears upper 32 bits of the int destination.
// - Exponent move: exponent to 16:0, sign to 17, rest zero.
// - Significand move copies the significand unchanged.
// - Every move sets deferred-exception bit exactly when source is not-a-thing.
// - Move faults if the float source register is disabled.
// - Swap and XOR fault if destination or either source is disabled.

module fp_register_bit_ops
    import fp_bit_ops_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Issue
    input  wire logic        op_valid,
    input  wire logic [3:0]  op_code,
    input  wire logic        qualifying_predicate,
    input  wire logic [6:0]  dst_idx,
    // Float sources and state
    input  wire float_reg_s  float_reg_src2,
    input  wire float_reg_s  float_reg_src3,
    input  wire logic        src2_disabled,
    input  wire logic        src3_disabled,
    input  wire logic        dst_disabled,
    // Float destination write
    output float_reg_s       float_reg_wdata,
    output logic             float_reg_we,
    output logic [6:0]       float_reg_widx,
    // Integer destination write
    output logic [63:0]      int_reg_wdata,
    output logic             int_reg_nat,
    output logic             int_reg_we,
    output logic [6:0]       int_reg_widx,
    // Fault and status
    output logic             disabled_fault,
    output logic             float_modified_flag_update,
    output logic [6:0]       modified_idx
);

    fp_mem_if mem ();

    fp_mem_format u_conv (
        .m (mem.conv)
    );

    float_reg_s  fwd_reg,  fwd_next;
    logic        fwe_reg,  fwe_next;
    logic [63:0] iwd_reg,  iwd_next;
    logic        nat_reg,  nat_next;
    logic        iwe_reg,  iwe_next;
    logic [6:0]  idx_reg,  idx_next;
    logic        flt_reg,  flt_next;
    logic        mod_reg,  mod_next;

    logic        natval2;
    logic        natval3;
    logic        is_fop;
    logic        is_move;
    logic [31:0] hi;
    logic [31:0] lo;
    fp_op_e      op;

    // ----------------------------------------------------------------
    // Operand classification
    // ----------------------------------------------------------------
    assign op      = fp_op_e'(op_code);
    assign natval2 = (float_reg_src2.exponent == `FPB_NATVAL_EXP) &&
                     (float_reg_src2.significand == `FPB_NATVAL_SIG) &&
                     (float_reg_src2.sign == `FPB_NATVAL_SIGN);
    assign natval3 = (float_reg_src3.exponent == `FPB_NATVAL_EXP) &&
                     (float_reg_src3.significand == `FPB_NATVAL_SIG) &&
                     (float_reg_src3.sign == `FPB_NATVAL_SIGN);
    assign is_fop  = (op_code <= 4'h5);
    assign is_move = (op_code >= 4'h6) && (op_code <= 4'h9);
    assign mem.src = float_reg_src2;

    // ----------------------------------------------------------------
    // Result halves for swap and sign-extend
    // ----------------------------------------------------------------
    always_comb
    begin
        hi = float_reg_src3.significand[31:0];
        lo = float_reg_src2.significand[63:32];
        case (op)
            OP_HALF_SWAP:
            begin
                hi = float_reg_src3.significand[31:0];
                lo = float_reg_src2.significand[63:32];
            end
            OP_HALF_SWAP_NEG_LEFT:
            begin
                hi = {~float_reg_src3.significand[31], float_reg_src3.significand[30:0]};
                lo = float_reg_src2.significand[63:32];
            end
            OP_HALF_SWAP_NEG_RIGHT:
            begin
                hi = float_reg_src3.significand[31:0];
                lo = {~float_reg_src2.significand[63], float_reg_src2.significand[62:32]};
            end
            OP_SXT_LEFT:
            begin
                hi = {32{float_reg_src2.significand[63]}};
                lo = float_reg_src3.significand[63:32];
            end
            OP_SXT_RIGHT:
            begin
                hi = {32{float_reg_src2.significand[31]}};
                lo = float_reg_src3.significand[31:0];
            end
            default:
            begin
                hi = float_reg_src3.significand[31:0];
                lo = float_reg_src2.significand[63:32];
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next-state: results, faults, status
    // ----------------------------------------------------------------
    always_comb
    begin
        fwd_next = fwd_reg;
        fwe_next = 1'b0;
        iwd_next = iwd_reg;
        nat_next = nat_reg;
        iwe_next = 1'b0;
        idx_next = idx_reg;
        flt_next = 1'b0;
        mod_next = 1'b0;
        if (op_valid && qualifying_predicate)
        begin
            idx_next = dst_idx;
            if (is_fop)
            begin
                if (dst_disabled || src2_disabled || src3_disabled)
                begin
                    flt_next = 1'b1;
                end
                else
                begin
                    fwe_next = 1'b1;
                    mod_next = 1'b1;
                    if (natval2 || natval3)
                    begin
                        fwd_next = {`FPB_NATVAL_SIGN, `FPB_NATVAL_EXP, `FPB_NATVAL_SIG};
                    end
                    else
                    begin
                        fwd_next.sign     = `FPB_SIGN_POS;
                        fwd_next.exponent = `FPB_INT_EXP;
                        if (op == OP_XOR)
                            fwd_next.significand = float_reg_src2.significand ^
                                                   float_reg_src3.significand;
                        else
                            fwd_next.significand = {hi, lo};
                    end
                end
            end
            else if (is_move)
            begin
                if (src2_disabled)
                begin
                    flt_next = 1'b1;
                end
                else
                begin
                    iwe_next = 1'b1;
                    nat_next = natval2;
                    case (op)
                        OP_GET_SINGLE:
                            iwd_next = {32'h0000_0000, mem.single_val};
                        OP_GET_DOUBLE:
                            iwd_next = mem.double_val;
                        OP_GET_EXP:
                            iwd_next = {46'h0, float_reg_src2.sign, float_reg_src2.exponent};
                        OP_GET_SIG:
                            iwd_next = float_reg_src2.significand;
                        default:
                            iwd_next = iwd_reg;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            fwd_reg <= '0;
            fwe_reg <= 1'b0;
            iwd_reg <= 64'h0000_0000_0000_0000;
            nat_reg <= 1'b0;
            iwe_reg <= 1'b0;
            idx_reg <= 7'h00;
            flt_reg <= 1'b0;
            mod_reg <= 1'b0;
        end
        else
        begin
            fwd_reg <= fwd_next;
            fwe_reg <= fwe_next;
            iwd_reg <= iwd_next;
            nat_reg <= nat_next;
            iwe_reg <= iwe_next;
            idx_reg <= idx_next;
            flt_reg <= flt_next;
            mod_reg <= mod_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs straight from flops
    // ----------------------------------------------------------------
    assign float_reg_wdata            = fwd_reg;
    assign float_reg_we               = fwe_reg;
    assign float_reg_widx             = idx_reg;
    assign int_reg_wdata              = iwd_reg;
    assign int_reg_nat                = nat_reg;
    assign int_reg_we                 = iwe_reg;
    assign int_reg_widx               = idx_reg;
    assign disabled_fault             = flt_reg;
    assign float_modified_flag_update = mod_reg;
    assign modified_idx               = idx_reg;

endmodule

// ==== writeback_sink.sv ====
`timescale 1ns/1ps

// Register-file side: counts the write strobes it receives
module writeback_sink (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Write strobes
    input  wire logic float_we,
    input  wire logic int_we,
    // Counts
    output int        f_cnt,
    output int        i_cnt
);
    // Tally of accepted writes
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            f_cnt <= 0;
            i_cnt <= 0;
        end
        else
        begin
            f_cnt <= f_cnt + int'(float_we);
            i_cnt <= i_cnt + int'(int_we);
        end
    end
endmodule

// ==== fp_register_bit_ops_chk.sv ====
`timescale 1ns/1ps
`include "fp_bit_ops_regs.svh"

module fp_register_bit_ops_chk
    import fp_bit_ops_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Issue
    input  wire logic       op_valid,
    input  wire logic [3:0] op_code,
    input  wire logic       qualifying_predicate,
    input  wire logic [6:0] dst_idx,
    input  wire float_reg_s float_reg_src2,
    input  wire float_reg_s float_reg_src3,
    input  wire logic       src2_disabled,
    input  wire logic       src3_disabled,
    input  wire logic       dst_disabled,
    // Results
    input  wire float_reg_s float_reg_wdata,
    input  wire logic       float_reg_we,
    input  wire logic [6:0] float_reg_widx,
    input  wire logic [63:0] int_reg_wdata,
    input  wire logic       int_reg_nat,
    input  wire logic       int_reg_we,
    input  wire logic       disabled_fault,
    input  wire logic       float_modified_flag_update,
    input  wire logic [6:0] modified_idx
);
    localparam float_reg_s natval_val = '{`FPB_NATVAL_SIGN, `FPB_NATVAL_EXP, `FPB_NATVAL_SIG};
    logic nat2;
    logic nat3;
    logic dis_any;

    // Operand classification
    assign nat2    = float_reg_src2 == natval_val;
    assign nat3    = float_reg_src3 == natval_val;
    assign dis_any = src2_disabled | src3_disabled | dst_disabled;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Issue steps
    sequence s_take; op_valid && qualifying_predicate; endsequence
    sequence s_fop; s_take ##0 op_code <= 4'h5; endsequence
    sequence s_mov; s_take ##0 (op_code >= 4'h6 && op_code <= 4'h9); endsequence

    property p_f_write; s_fop ##0 !dis_any |=> float_reg_we && float_reg_widx == $past(dst_idx); endproperty
    a_f_write: assert property (p_f_write) else $error("float write missing");
    property p_f_fault; s_fop ##0 dis_any |=> disabled_fault && !float_reg_we; endproperty
    a_f_fault: assert property (p_f_fault) else $error("float op fault wrong");
    property p_m_fault; s_mov ##0 src2_disabled |=> disabled_fault && !int_reg_we; endproperty
    a_m_fault: assert property (p_m_fault) else $error("move fault wrong");
    property p_m_write; s_mov ##0 !src2_disabled |=> int_reg_we && int_reg_nat == $past(nat2); endproperty
    a_m_write: assert property (p_m_write) else $error("move write or nat wrong");
    property p_quiet;
        op_valid && !qualifying_predicate |=> !float_reg_we && !int_reg_we && !disabled_fault;
    endproperty
    a_quiet: assert property (p_quiet) else $error("false predicate acted");
    property p_nat; s_fop ##0 !dis_any && (nat2 || nat3) |=> float_reg_wdata == natval_val; endproperty
    a_nat: assert property (p_nat) else $error("natval not written");
    property p_xor;
        s_take ##0 op_code == 4'h5 && !dis_any && !nat2 && !nat3 |=>
            float_reg_wdata == {1'b0, 17'h1_003E, $past(float_reg_src2.significand ^ float_reg_src3.significand)};
    endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong");
    property p_exp;
        s_mov ##0 op_code == 4'h8 && !src2_disabled |=>
            int_reg_wdata == {46'h0, $past(float_reg_src2.sign), $past(float_reg_src2.exponent)};
    endproperty
    a_exp: assert property (p_exp) else $error("exponent move wrong");
    property p_sig;
        s_mov ##0 op_code == 4'h9 && !src2_disabled |=> int_reg_wdata == $past(float_reg_src2.significand);
    endproperty
    a_sig: assert property (p_sig) else $error("significand move wrong");
    property p_mod;
        s_fop ##0 !dis_any |=> float_modified_flag_update && modified_idx == $past(dst_idx);
    endproperty
    a_mod: assert property (p_mod) else $error("modified flag missing");
endmodule

// ==== fp_register_bit_ops_test.sv ====
`timescale 1ns/1ps

module fp_register_bit_ops_test
    import fp_bit_ops_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    logic [3:0] op_code = 4'h0;
    logic qualifying_predicate = 1'b0;
    logic [6:0] dst_idx = 7'h00;
    float_reg_s src2 = '0;
    float_reg_s src3 = '0;
    logic [2:0] dis = 3'b000;
    float_reg_s wdata;
    logic fwe, inat, iwe, fault, fmod;
    logic [6:0] fidx, iidx, midx;
    logic [63:0] idata;
    int f_cnt, i_cnt, fails = 0, checked = 0;
    float_reg_s a = '{1'b1, 17'h0_1234, 64'h8765_4321_0FED_CBA9};
    float_reg_s b = '{1'b0, 17'h0_FFFF, 64'hF0F0_1234_5678_9ABC};
    float_reg_s nv = '{1'b0, 17'h1_FFFE, 64'h0000_0000_0000_0000};

    fp_register_bit_ops fp_register_bit_ops_i (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid),
        .op_code(op_code), .qualifying_predicate(qualifying_predicate), .dst_idx(dst_idx),
        .float_reg_src2(src2), .float_reg_src3(src3), .src2_disabled(dis[0]), .src3_disabled(dis[1]),
        .dst_disabled(dis[2]), .float_reg_wdata(wdata), .float_reg_we(fwe), .float_reg_widx(fidx),
        .int_reg_wdata(idata), .int_reg_nat(inat), .int_reg_we(iwe), .int_reg_widx(iidx),
        .disabled_fault(fault), .float_modified_flag_update(fmod), .modified_idx(midx));
    writeback_sink writeback_sink_i (.ref_clk(ref_clk), .rst_n(rst_n), .float_we(fwe), .int_we(iwe),
        .f_cnt(f_cnt), .i_cnt(i_cnt));

    // Clock
    always #20 ref_clk = ~ref_clk;

    task automatic chk(input logic [81:0] seen, input logic [81:0] exp, input string msg);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // One-cycle issue; returns once the answer edge has landed
    task automatic issue(input logic [3:0] c, input logic p, input float_reg_s s2, input float_reg_s s3,
                         input logic [2:0] d);
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_code <= c;
        qualifying_predicate <= p;
        dst_idx <= 7'h20 + 7'(c);
        src2 <= s2;
        src3 <= s3;
        dis <= d;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        #1;
    endtask

    function automatic float_reg_s fexp(input logic [3:0] c, input float_reg_s s2, input float_reg_s s3);
        logic [31:0] hi;
        logic [31:0] lo;
        {hi, lo} = {s3.significand[31:0], s2.significand[63:32]};
        if (c == 4'h1) hi[31] = ~hi[31];
        if (c == 4'h2) lo[31] = ~lo[31];
        if (c == 4'h3) {hi, lo} = {{32{s2.significand[63]}}, s3.significand[63:32]};
        if (c == 4'h4) {hi, lo} = {{32{s2.significand[31]}}, s3.significand[31:0]};
        fexp = '{1'b0, 17'h1_003E, {hi, lo}};
        if (c == 4'h5) fexp.significand = s2.significand ^ s3.significand;
    endfunction

    task automatic test_float();
        for (int i = 0; i < 12; i++)
        begin
            float_reg_s x = (i < 6) ? a : b;
            float_reg_s y = (i < 6) ? b : a;
            issue(4'(i % 6), 1'b1, x, y, 3'b000);
            chk(fwe, 1'b1, "float write strobe");
            chk(wdata, fexp(4'(i % 6), x, y), "float result");
            chk({fmod, midx, fidx}, {1'b1, 7'h20 + 7'(i % 6), 7'h20 + 7'(i % 6)}, "float index");
        end
        $display("test float done");
    endtask

    task automatic test_moves();
        float_reg_s one = '{1'b0, 17'h0_FFFF, 64'h8000_0000_0000_0000};
        issue(4'h6, 1'b1, one, b, 3'b000);
        chk({iwe, inat, idata}, {2'b10, 64'h0000_0000_3F80_0000}, "single move");
        issue(4'h7, 1'b1, one, b, 3'b000);
        chk({iwe, idata}, {1'b1, 64'h3FF0_0000_0000_0000}, "double move");
        issue(4'h8, 1'b1, a, b, 3'b000);
        chk(idata, {46'h0, 1'b1, 17'h0_1234}, "exponent move");
        issue(4'h9, 1'b1, a, b, 3'b000);
        chk({inat, idata, iidx}, {1'b0, a.significand, 7'h29}, "significand move");
        $display("test moves done");
    endtask

    task automatic test_natval();
        issue(4'h0, 1'b1, a, nv, 3'b000);
        chk(wdata, nv, "natval third source");
        issue(4'h3, 1'b1, nv, b, 3'b000);
        chk(wdata, nv, "natval second source");
        issue(4'h9, 1'b1, nv, a, 3'b000);
        chk({iwe, inat}, 2'b11, "natval move deferral");
        $display("test natval done");
    endtask

    task automatic test_disabled();
        for (int i = 0; i < 3; i++)
        begin
            issue(4'h5, 1'b1, a, b, 3'(1 << i));
            chk({fault, fwe, fmod}, 3'b100, "disabled float operand");
        end
        issue(4'h7, 1'b1, a, b, 3'b110);
        chk({fault, iwe}, 2'b01, "move ignores other operands");
        issue(4'h7, 1'b1, a, b, 3'b001);
        chk({fault, iwe}, 2'b10, "disabled move source");
        $display("test disabled done");
    endtask

    task automatic test_pred();
        int f0 = f_cnt;
        int i0 = i_cnt;
        issue(4'h5, 1'b0, a, b, 3'b001);
        chk(fault, 1'b0, "false predicate fault");
        issue(4'h9, 1'b0, a, b, 3'b000);
        issue(4'hA, 1'b1, a, b, 3'b000);
        @(posedge ref_clk);
        #1;
        chk({f_cnt, i_cnt}, {f0, i0}, "false predicate write");
        $display("test predicate done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_float();
        test_moves();
        test_natval();
        test_disabled();
        test_pred();
        report_and_stop();
    end
endmodule

bind fp_register_bit_ops fp_register_bit_ops_chk fp_register_bit_ops_chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .op_valid(op_valid), .op_code(op_code), .qualifying_predicate(qualifying_predicate), .dst_idx(dst_idx),
    .float_reg_src2(float_reg_src2), .float_reg_src3(float_reg_src3), .src2_disabled(src2_disabled),
    .src3_disabled(src3_disabled), .dst_disabled(dst_disabled), .float_reg_wdata(float_reg_wdata),
    .float_reg_we(float_reg_we), .float_reg_widx(float_reg_widx), .int_reg_wdata(int_reg_wdata),
    .int_reg_nat(int_reg_nat), .int_reg_we(int_reg_we), .disabled_fault(disabled_fault),
    .float_modified_flag_update(float_modified_flag_update), .modified_idx(modified_idx));
